// ---- core/ebt_pkg.sv ----
// Constants, register map and types of the event timer block.
// Assumes APB with one 32-bit word per register, byte address = 4 * index.
package ebt_pkg;
  // Register indices, byte address is four times these
  localparam logic [3:0] IDX_CONTROL_ONE = 4'h0;
  localparam logic [3:0] IDX_CONTROL_TWO = 4'h1;
  localparam logic [3:0] IDX_EVENT_CONTROL = 4'h4;
  localparam logic [3:0] IDX_INTERRUPT_ENABLES = 4'h5;
  localparam logic [3:0] IDX_INTERRUPT_FLAGS = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;
  localparam logic [3:0] IDX_COUNT_VALUE = 4'hA;
  localparam logic [3:0] IDX_COMPARE_CAPTURE_VALUE = 4'hC;
  // Field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_CLK_SEL = 1;
  localparam int POS_SYNC_RESTART = 4;
  localparam int POS_CASCADE = 5;
  localparam int POS_RUN_STANDBY = 6;
  localparam int POS_MODE = 0;
  localparam int POS_ASYNC = 6;
  localparam int POS_CAPTURE_FLAG_IE = 0;
  localparam int POS_EDGE = 4;
  localparam int POS_FILTER = 6;
  localparam int POS_CAPTURE_FLAG = 0;
  localparam int POS_OVF = 1;
  localparam int POS_RUN = 0;
  // Reset values and counter maximum
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Filter depth in peripheral clock cycles
  localparam int FILTER_DEPTH = 4;
  // Count clock selections
  localparam logic [2:0] CSEL_DIV1 = 3'h0;
  localparam logic [2:0] CSEL_DIV2 = 3'h1;
  localparam logic [2:0] CSEL_COMP0 = 3'h2;
  localparam logic [2:0] CSEL_COMP1 = 3'h3;
  localparam logic [2:0] CSEL_EVENT = 3'h7;
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'b000,
    MODE_TIMEOUT  = 3'b001,
    MODE_CAPTURE  = 3'b010,
    MODE_FREQ     = 3'b011,
    MODE_PULSE    = 3'b100,
    MODE_FREQ_PW  = 3'b101,
    MODE_SINGLE   = 3'b110,
    MODE_PWM8     = 3'b111
  } ebt_mode_t;
endpackage

// ---- core/ebt_edge_if.sv ----
// Carrier for a detected capture input: stable level and edge pulses.
// Assumes one clock domain, core_clk.
`timescale 1ns/100ps
`default_nettype none
interface ebt_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ---- core/ebt_noise_filter.sv ----
// Capture input noise filter and edge detector.
// Assumes the raw input is already in the core_clk domain.
`timescale 1ns/100ps
`default_nettype none
module ebt_noise_filter
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Input and control
  input  wire logic raw_in,
  input  wire logic filter_en,
  // Detected level and edges
  ebt_edge_if.src   edge_o
);
  typedef struct packed {
    logic [FILTER_DEPTH-1:0] samp;
    logic                    stable;
    logic                    prev;
  } ebt_flt_t;
  ebt_flt_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.samp = {st.samp[FILTER_DEPTH-2:0], raw_in};
    next_st.prev = st.stable;
    if (!filter_en) begin
      next_st.stable = raw_in;
    end else if (&st.samp || ~|st.samp) begin
      next_st.stable = st.samp[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_o.level = st.stable;
  assign edge_o.rise = st.stable & ~st.prev;
  assign edge_o.fall = ~st.stable & st.prev;

  property p_filter_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (filter_en && !(&st.samp) && (|st.samp)) |=> (st.stable == $past(st.stable));
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter level moved on disagreement");
endmodule
`default_nettype wire

// ---- core/ebt_async_catch.sv ----
// Clockless catch of capture input edges for asynchronous single-shot.
// Assumes the event line may pulse shorter than one core_clk period.
`timescale 1ns/100ps
`default_nettype none
module ebt_async_catch (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Raw event line and caught pulse
  input  wire logic evt_in,
  output logic      caught
);
  logic       tgl;
  logic [2:0] sync;

  // Toggle on the event edge itself, no clock needed
  always_ff @(posedge evt_in or negedge rst_n) begin
    if (!rst_n) begin
      tgl <= 1'b0;
    end else begin
      tgl <= ~tgl;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], tgl};
    end
  end

  assign caught = sync[2] ^ sync[1];
endmodule
`default_nettype wire

// ---- core/ebt_timer.sv ----
// Event timer: 16-bit counter with capture, cascade, filter and events.
// Assumes event network and companion timer run on core_clk; APB slave.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ebt_timer
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Event inputs
  input  wire logic        capture_flag_evt_in,
  input  wire logic        count_evt_in,
  // Companion timer
  input  wire logic [1:0]  comp_count_tick,
  input  wire logic [1:0]  comp_restart,
  // Sleep state
  input  wire logic        standby_sleep,
  input  wire logic        powerdown_sleep,
  // Event and request outputs
  output logic             capture_flag_evt_out,
  output logic             ovf_evt_out,
  output logic             irq
);
  import ebt_pkg::*;

  typedef struct packed {
    logic        enable;
    logic [2:0]  count_clock_select;
    logic        sync_restart_enable;
    logic        cascade;
    logic        run_in_standby;
    logic [2:0]  timer_mode_field;
    logic        async_en;
    logic        capture_input_enable;
    logic        edge_sel;
    logic        filter_en;
    logic [1:0]  interrupt_enables;
    logic [1:0]  interrupt_flags;
    logic [15:0] count_value;
    logic [15:0] compare_capture_value;
    logic        div2;
    logic        cnt_evt_q;
    logic        dly_rise;
    logic        dly_fall;
    logic        running;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        capture_flag_out;
    logic        ovf_out;
    logic        irq;
  } ebt_state_t;

  ebt_state_t st, next_st;

  // ---------------------------------------------------------------
  // Capture input paths
  // ---------------------------------------------------------------
  ebt_edge_if capture_flag_edge ();
  logic       async_pulse;

  ebt_noise_filter u_filter (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .raw_in    (capture_flag_evt_in),
    .filter_en (st.filter_en),
    .edge_o    (capture_flag_edge)
  );

  ebt_async_catch u_async (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .evt_in   (capture_flag_evt_in),
    .caught   (async_pulse)
  );

  // ---------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------
  logic       halted;
  logic       tick;
  logic       restart;
  logic       sel_rise;
  logic       sel_fall;
  logic       capture_flag_trig;
  logic       do_capture_flag;
  logic       do_ovf;
  logic       acc;
  logic       mapped;
  logic [3:0] idx;
  logic [1:0] clr_flags;
  ebt_mode_t  mode;

  assign mode = ebt_mode_t'(st.timer_mode_field);
  assign idx = paddr[5:2];
  assign acc = psel & penable & st.pready;
  assign halted = powerdown_sleep | (standby_sleep & ~st.run_in_standby);

  always_comb begin
    tick = 1'b0;
    case (st.count_clock_select)
      CSEL_DIV1:  tick = 1'b1;
      CSEL_DIV2:  tick = st.div2;
      CSEL_COMP0: tick = comp_count_tick[0];
      CSEL_COMP1: tick = comp_count_tick[1];
      CSEL_EVENT: tick = count_evt_in & ~st.cnt_evt_q;
      default:    tick = 1'b0;
    endcase
  end

  // Restart follows the selected companion, else the first one
  assign restart = st.sync_restart_enable &
                   ((st.count_clock_select == CSEL_COMP1) ? comp_restart[1] : comp_restart[0]);

  // Cascade delays the capture edges by one cycle to line up with the lower half's carry
  assign sel_rise = st.cascade ? st.dly_rise : capture_flag_edge.rise;
  assign sel_fall = st.cascade ? st.dly_fall : capture_flag_edge.fall;

  always_comb begin
    capture_flag_trig = 1'b0;
    if (st.capture_input_enable) begin
      if (mode == MODE_SINGLE && st.async_en) begin
        capture_flag_trig = async_pulse;
      end else if (mode == MODE_SINGLE) begin
        capture_flag_trig = sel_rise | (st.edge_sel & sel_fall);
      end else begin
        capture_flag_trig = st.edge_sel ? sel_fall : sel_rise;
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    case (idx)
      IDX_CONTROL_ONE, IDX_CONTROL_TWO, IDX_EVENT_CONTROL, IDX_INTERRUPT_ENABLES,
      IDX_INTERRUPT_FLAGS, IDX_STATUS, IDX_COUNT_VALUE, IDX_COMPARE_CAPTURE_VALUE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign clr_flags = (acc && pwrite && idx == IDX_INTERRUPT_FLAGS) ? pwdata[1:0] : 2'h0;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    do_capture_flag = 1'b0;
    do_ovf = 1'b0;
    next_st.cnt_evt_q = count_evt_in;
    next_st.dly_rise = capture_flag_edge.rise;
    next_st.dly_fall = capture_flag_edge.fall;
    next_st.capture_flag_out = 1'b0;
    next_st.ovf_out = 1'b0;
    if (st.enable && !halted) begin
      next_st.div2 = ~st.div2;
      if (restart) begin
        next_st.count_value = RST_COUNT;
      end else if (tick && (mode != MODE_SINGLE || st.running)) begin
        next_st.count_value = st.count_value + 16'h0001;
        if (st.count_value == COUNT_MAX) begin
          do_ovf = 1'b1;
        end
      end
      case (mode)
        MODE_PERIODIC: begin
          if (tick && st.count_value == st.compare_capture_value) begin
            do_capture_flag = 1'b1;
            next_st.count_value = RST_COUNT;
          end
        end
        MODE_CAPTURE: begin
          if (capture_flag_trig) begin
            next_st.compare_capture_value = st.count_value;
            do_capture_flag = 1'b1;
          end
        end
        MODE_FREQ: begin
          if (capture_flag_trig) begin
            next_st.compare_capture_value = st.count_value;
            next_st.count_value = RST_COUNT;
            do_capture_flag = 1'b1;
          end
        end
        MODE_SINGLE: begin
          if (capture_flag_trig && !st.running) begin
            next_st.running = 1'b1;
            next_st.count_value = RST_COUNT;
          end else if (st.running && tick && st.count_value == st.compare_capture_value) begin
            next_st.running = 1'b0;
            do_capture_flag = 1'b1;
          end
        end
        default: begin
          do_capture_flag = 1'b0;
        end
      endcase
    end
    // Hardware set wins over software clear
    next_st.interrupt_flags = (st.interrupt_flags & ~clr_flags) | {do_ovf, do_capture_flag};
    next_st.capture_flag_out = do_capture_flag;
    next_st.ovf_out = do_ovf;
    next_st.irq = |(next_st.interrupt_flags & st.interrupt_enables);

    // APB: one wait cycle, answer registered
    next_st.pready = psel & penable & ~st.pready;
    next_st.pslverr = psel & penable & ~st.pready & ~mapped;
    if (psel && penable && !st.pready && !pwrite) begin
      next_st.prdata = 32'h0000_0000;
      case (idx)
        IDX_CONTROL_ONE: next_st.prdata[6:0] = {st.run_in_standby, st.cascade, st.sync_restart_enable,
                                                  st.count_clock_select, st.enable};
        IDX_CONTROL_TWO: next_st.prdata[6:0] = {st.async_en, 3'h0, st.timer_mode_field};
        IDX_EVENT_CONTROL: next_st.prdata[6:0] = {st.filter_en, 1'b0, st.edge_sel, 3'h0,
                                                    st.capture_input_enable};
        IDX_INTERRUPT_ENABLES: next_st.prdata[1:0] = st.interrupt_enables;
        IDX_INTERRUPT_FLAGS: next_st.prdata[1:0] = st.interrupt_flags;
        IDX_STATUS: next_st.prdata[POS_RUN] = st.running;
        IDX_COUNT_VALUE: next_st.prdata[15:0] = st.count_value;
        IDX_COMPARE_CAPTURE_VALUE: next_st.prdata[15:0] = st.compare_capture_value;
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite && mapped) begin
      case (idx)
        IDX_CONTROL_ONE: begin
          next_st.enable = pwdata[POS_ENABLE];
          next_st.count_clock_select = pwdata[POS_CLK_SEL +: 3];
          next_st.sync_restart_enable = pwdata[POS_SYNC_RESTART];
          next_st.cascade = pwdata[POS_CASCADE];
          next_st.run_in_standby = pwdata[POS_RUN_STANDBY];
        end
        IDX_CONTROL_TWO: begin
          next_st.timer_mode_field = pwdata[POS_MODE +: 3];
          next_st.async_en = pwdata[POS_ASYNC];
        end
        IDX_EVENT_CONTROL: begin
          next_st.capture_input_enable = pwdata[POS_CAPTURE_FLAG_IE];
          next_st.edge_sel = pwdata[POS_EDGE];
          next_st.filter_en = pwdata[POS_FILTER];
        end
        IDX_INTERRUPT_ENABLES: next_st.interrupt_enables = pwdata[1:0];
        IDX_COUNT_VALUE: next_st.count_value = pwdata[15:0];
        IDX_COMPARE_CAPTURE_VALUE: next_st.compare_capture_value = pwdata[15:0];
        default: next_st.running = st.running;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign capture_flag_evt_out = st.capture_flag_out;
  assign ovf_evt_out = st.ovf_out;
  assign irq = st.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_capture_copy;
    @(posedge core_clk) disable iff (!rst_n)
      (st.enable && !halted && mode == MODE_CAPTURE && capture_flag_trig && !(acc && pwrite))
        |=> (st.compare_capture_value == $past(st.count_value)) && st.interrupt_flags[POS_CAPTURE_FLAG];
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy count");

  property p_ovf_wrap;
    @(posedge core_clk) disable iff (!rst_n)
      (do_ovf && !(acc && pwrite)) |=> st.interrupt_flags[POS_OVF] && st.ovf_out;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow not flagged");

  property p_event_match;
    @(posedge core_clk) disable iff (!rst_n)
      (!$rose(st.interrupt_flags[POS_CAPTURE_FLAG]) || st.capture_flag_out) && (!st.capture_flag_out || st.interrupt_flags[POS_CAPTURE_FLAG]);
  endproperty
  a_event_match: assert property (p_event_match) else $error("capture event without flag");

  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
      st.irq == |(st.interrupt_flags & $past(st.interrupt_enables));
  endproperty
  a_irq: assert property (p_irq) else $error("request does not follow flag and enable");

  property p_powerdown;
    @(posedge core_clk) disable iff (!rst_n)
      (powerdown_sleep && !(acc && pwrite)) |=> $stable(st.count_value) && !st.capture_flag_out && !st.ovf_out;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("activity in power-down");

  property p_standby;
    @(posedge core_clk) disable iff (!rst_n)
      (standby_sleep && !st.run_in_standby && !(acc && pwrite)) |=> $stable(st.count_value);
  endproperty
  a_standby: assert property (p_standby) else $error("counted in standby");

  property p_sync_restart;
    @(posedge core_clk) disable iff (!rst_n)
      (st.enable && !halted && restart && mode == MODE_CAPTURE && !(acc && pwrite))
        |=> st.count_value == RST_COUNT;
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("no restart with companion");

  property p_event_ignored;
    @(posedge core_clk) disable iff (!rst_n)
      (st.enable && !halted && st.count_clock_select == CSEL_COMP0 && !comp_count_tick[0] && !restart
       && mode == MODE_CAPTURE && !(acc && pwrite)) |=> $stable(st.count_value);
  endproperty
  a_event_ignored: assert property (p_event_ignored) else $error("counted without selected clock");

  property p_cascade_delay;
    @(posedge core_clk) disable iff (!rst_n)
      (st.cascade && st.enable && !halted && mode == MODE_CAPTURE && st.capture_input_enable && !st.edge_sel
       && capture_flag_edge.rise && !st.dly_rise) |=> !st.capture_flag_out;
  endproperty
  a_cascade_delay: assert property (p_cascade_delay) else $error("cascade delay missing");

  c_capture: cover property (@(posedge core_clk) disable iff (!rst_n) st.capture_flag_out);
  c_overflow: cover property (@(posedge core_clk) disable iff (!rst_n) st.ovf_out);
  c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) st.irq);
endmodule
`default_nettype wire

// ---- verification/ebt_companion_model.sv ----
// Companion timer model: prescaled count enables and restart pulses.
// Assumes it shares core_clk and rst_n with the event timer.
`timescale 1ns/100ps
`default_nettype none
module ebt_companion_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Prescaled ticks and restarts
  output logic [1:0]      tick,
  output logic [1:0]      restart
);
  logic [5:0] cnt;
  // Free-running prescaler; ticks every 4 and 8 cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 6'h00;
      tick    <= 2'h0;
      restart <= 2'h0;
    end else begin
      cnt        <= cnt + 6'h01;
      tick[0]    <= (cnt[1:0] == 2'h3);
      tick[1]    <= (cnt[2:0] == 3'h7);
      restart[0] <= (cnt[4:0] == 5'h1F);
      restart[1] <= (cnt == 6'h3F);
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench of the event timer, random event counts.
// Assumes APB slave answers with one wait state and the companion model.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ebt_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        psel_lo = 1'b0, tgt = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic [31:0] prdata_lo;
  logic        pready_lo, pslverr_lo, ovf_lo;
  logic [15:0] p;
  logic        capture_flag_evt_in = 1'b0, count_evt_in = 1'b0;
  logic        standby_sleep = 1'b0, powerdown_sleep = 1'b0;
  logic [1:0]  tick, restart;
  logic        capture_flag_evt_out, ovf_evt_out, irq;
  int          n_fail = 0, checks = 0, cyc = 0, seed = 24;
  int          n, k, l0;
  logic [31:0] d, d2;
  logic        e;

  always #50 core_clk = ~core_clk;

  ebt_companion_model comp (.core_clk(core_clk), .rst_n(rst_n), .tick(tick), .restart(restart));
  // Upper half counts the overflow events of the lower half
  ebt_timer dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_flag_evt_in(capture_flag_evt_in), .count_evt_in(ovf_lo), .comp_count_tick(tick),
    .comp_restart(restart), .standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep),
    .capture_flag_evt_out(capture_flag_evt_out), .ovf_evt_out(ovf_evt_out), .irq(irq));
  ebt_timer dut_lo (.core_clk(core_clk), .rst_n(rst_n), .psel(psel_lo), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_lo), .pready(pready_lo), .pslverr(pslverr_lo),
    .capture_flag_evt_in(capture_flag_evt_in), .count_evt_in(count_evt_in), .comp_count_tick(tick),
    .comp_restart(restart), .standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep),
    .capture_flag_evt_out(), .ovf_evt_out(ovf_lo), .irq());

  // ------------------------------
  // Checking and closing
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Joined 32-bit value after cnt events from a lower preset
  function automatic logic [31:0] exp_join(input logic [15:0] base, input int cnt);
    return {16'h0000, base} + cnt;
  endfunction

  task summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ------------------------------
  // APB master
  // ------------------------------
  task apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rd,
           output logic err);
    psel    <= ~tgt;
    psel_lo <= tgt;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while ((tgt ? pready_lo : pready) !== 1'b1);
    rd = tgt ? prdata_lo : prdata;
    err = tgt ? pslverr_lo : pslverr;
    psel    <= 1'b0;
    psel_lo <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task wr(input logic [3:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, d2, e);
  endtask

  task rd(input logic [3:0] idx, output logic [31:0] v);
    apb(1'b0, idx, 32'h0, v, e);
  endtask

  // Pulse the capture line and count cycles to the capture event
  task capture_flag_lat(input int hold, output int lat);
    capture_flag_evt_in <= 1'b1;
    lat = 0;
    repeat (12) begin
      @(posedge core_clk);
      if (lat == hold - 1)
        capture_flag_evt_in <= 1'b0;
      lat++;
      if (capture_flag_evt_out === 1'b1)
        break;
    end
    repeat (8) @(posedge core_clk);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(IDX_CONTROL_ONE, d);
    chk(d, 32'h0);
    rd(IDX_INTERRUPT_FLAGS, d);
    chk(d, 32'h0);
    apb(1'b0, 4'h2, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("test reset values done");

    // Cascade: lower half counts events, upper half its overflows
    n = 17 + ($random(seed) & 15);
    d = $random(seed);
    p = {12'hFFF, d[3:0]};
    tgt = 1'b1;
    wr(IDX_EVENT_CONTROL, 32'h1);
    wr(IDX_CONTROL_TWO, {29'h0, MODE_CAPTURE});
    wr(IDX_COUNT_VALUE, {16'h0000, p});
    wr(IDX_CONTROL_ONE, 32'h0000000F);
    tgt = 1'b0;
    wr(IDX_EVENT_CONTROL, 32'h1);
    wr(IDX_CONTROL_TWO, {29'h0, MODE_CAPTURE});
    wr(IDX_CONTROL_ONE, 32'h0000002F);
    repeat (n) begin
      count_evt_in <= 1'b1;
      @(posedge core_clk);
      count_evt_in <= 1'b0;
      @(posedge core_clk);
    end
    capture_flag_lat(3, l0);
    chk(l0, 32'd4);
    rd(IDX_COMPARE_CAPTURE_VALUE, d);
    tgt = 1'b1;
    rd(IDX_COMPARE_CAPTURE_VALUE, d2);
    tgt = 1'b0;
    chk(d2, exp_join(p, n) & 32'h0000FFFF);
    chk({d[15:0], d2[15:0]}, exp_join(p, n));
    rd(IDX_INTERRUPT_FLAGS, d);
    chk(d, 32'h1);
    $display("test event count capture done");

    // Filter: short glitch rejected, long pulse delayed four cycles
    wr(IDX_EVENT_CONTROL, 32'h41);
    capture_flag_lat(2, k);
    chk({31'h0, capture_flag_evt_out}, 32'h0);
    chk(k, 12);
    capture_flag_lat(6, k);
    chk(k, l0 + 4);
    $display("test filter done");

    // Overflow from MAX to zero, flag, event and request
    wr(IDX_EVENT_CONTROL, 32'h0);
    wr(IDX_INTERRUPT_FLAGS, 32'h3);
    wr(IDX_INTERRUPT_ENABLES, 32'h2);
    wr(IDX_CONTROL_ONE, 32'h1);
    wr(IDX_COUNT_VALUE, 32'h0000FFFD);
    k = 0;
    while (ovf_evt_out !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    chk({31'h0, k < 20}, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_INTERRUPT_FLAGS, d);
    chk(d & 32'h2, 32'h2);
    wr(IDX_INTERRUPT_FLAGS, 32'h2);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");

    // Sleep modes
    standby_sleep <= 1'b1;
    rd(IDX_COUNT_VALUE, d);
    repeat (10) @(posedge core_clk);
    rd(IDX_COUNT_VALUE, d2);
    chk(d2, d);
    wr(IDX_CONTROL_ONE, 32'h41);
    rd(IDX_COUNT_VALUE, d);
    repeat (10) @(posedge core_clk);
    rd(IDX_COUNT_VALUE, d2);
    chk({31'h0, d2 != d}, 32'h1);
    standby_sleep <= 1'b0;
    powerdown_sleep <= 1'b1;
    rd(IDX_COUNT_VALUE, d);
    repeat (10) @(posedge core_clk);
    rd(IDX_COUNT_VALUE, d2);
    chk(d2, d);
    powerdown_sleep <= 1'b0;
    $display("test sleep done");

    // Companion clocks and restart
    wr(IDX_CONTROL_ONE, 32'h5);
    wr(IDX_COUNT_VALUE, 32'h0);
    repeat (80) @(posedge core_clk);
    rd(IDX_COUNT_VALUE, d);
    chk({31'h0, d >= 17 && d <= 24}, 32'h1);
    wr(IDX_CONTROL_ONE, 32'h17);
    repeat (200) @(posedge core_clk);
    rd(IDX_COUNT_VALUE, d);
    chk({31'h0, d <= 9}, 32'h1);
    $display("test companion done");
    summarize();
  end
endmodule
`default_nettype wire
